// File: owit_loader.v
/*
 Option-word loader and instruction timing: latches options
 after reset, waits the set-up delay, applies the settings
 and paces instruction cycles,
 stretching some to two.
 Assumes programmer access only while i_prog_mode is high,
 and one i_instr_valid clock
 per executed instruction.
*/
`include "owit_map.vh"

// Overview of operation
// - word0 bit12 zero makes pin external reset
// - word0 bit11 zero enables the watchdog
// - word0 bit10 picks two or four periods
// - word0 bits9:8 pick oscillator mode
// - word0 bits6:5 pick oscillator set-up delay
// - word0 bit3 picks port pin or oscillator out
// - word1 bits1:0 pick internal RC frequency
// - running code cannot reach option words
// - instructions are 13 bits, 8/10-bit literals
// - program counter writes take two cycles
// - branches, returns, taken skips take two cycles
// - timer clock follows instruction cycle divider
// - bit operations reach every register alike
// - sleep and watchdog-clear opcodes update flags
// - return pops stack, interrupt return re-enables
module owit_loader #(
   parameter [31:0] SETUP_18_CYC = `OWIT_SUT_18_US * (`OWIT_CLK_KHZ / 1000),
   parameter [31:0] SETUP_4P5_CYC = `OWIT_SUT_4P5_US * (`OWIT_CLK_KHZ / 1000),
   parameter [31:0] SETUP_288_CYC = `OWIT_SUT_288_US * (`OWIT_CLK_KHZ / 1000),
   parameter [31:0] SETUP_72_CYC = `OWIT_SUT_72_US * (`OWIT_CLK_KHZ / 1000)
) (
   input wire i_clk,              // oscillator clock, 40 MHz
   input wire i_rst_n,            // power-on reset, synchronous, active low
   input wire [1:0] i_addr,       // register port address
   input wire [15:0] i_wdata,     // register port write data
   input wire i_wr,               // register port write strobe
   input wire i_rd,               // register port read strobe
   output wire [15:0] o_rdata,    // read data, cycle after the read strobe
   input wire i_prog_mode,        // programmer attached, core not executing
   input wire i_reset_pin,        // shared reset pin, raw
   input wire i_wake,             // wake-up event from sleep
   input wire [12:0] i_instr,     // instruction being executed
   input wire i_instr_valid,      // instruction starts this clock
   input wire i_skip_taken,       // tested skip condition is true
   output wire o_core_rst_n,      // core held in reset, active low
   output wire o_fetch,           // fetch the next instruction
   output wire o_tmr_tick,        // timer/counter internal clock pulse
   output wire o_reset_pin_en,    // pin acts as external reset
   output wire o_wdt_en,          // watchdog timer enabled
   output wire o_four_period,     // four oscillator periods per cycle
   output wire [1:0] o_osc_mode,  // oscillator mode code
   output wire o_irc_sel,         // internal RC oscillator selected
   output wire o_code_protect,    // program memory read-out protected
   output wire o_osc_out_en,      // pin drives oscillator output
   output wire [1:0] o_rc_freq_sel, // internal RC frequency code
   output wire [12:0] o_cust_id,  // customer identification value
   output reg o_two_cycle,        // current instruction takes two cycles
   output reg o_sleep_req,        // sleep opcode executed, pulse
   output reg o_osc_stop,         // oscillator stopped for sleep
   output reg o_wdt_clear,        // clear the watchdog, pulse
   output reg o_to_flag,          // time-out flag
   output reg o_pd_flag,          // power-down flag
   output reg o_stack_pop,        // pop return stack into pc, pulse
   output reg o_irq_enable,       // re-enable interrupts, pulse
   output reg o_bit_op,           // bit set/clear/test on a register, pulse
   output reg [7:0] o_bit_mask,   // one-hot bit select of the bit operation
   output reg [5:0] o_reg_sel     // register addressed by the instruction
);
   localparam [2:0] ST_LOAD = 3'h0;
   localparam [2:0] ST_SETUP = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_SLEEP = 3'h3;

   reg [2:0] state;
   reg [1:0] load_idx;
   reg [23:0] setup_cnt;
   reg [12:0] opt_w0;
   reg [12:0] opt_w1;
   reg [12:0] opt_w2;
   reg pin_s1;
   reg pin_s2;
   reg extra_cycle;
   reg rd_pend;
   reg rd_stat;
   reg [15:0] status_q;
   reg [23:0] setup_lim;
   wire [12:0] mem_a;
   wire [12:0] mem_b;
   wire icycle;
   wire prog_wr;
   wire [12:0] wr_word;
   wire pin_reset;
   wire cfg_ok;
   wire running;

   // true when the instruction writes the program counter
   function owit_pc_write;
      input [12:0] ins;
      begin
         owit_pc_write = (ins[5:0] == `OWIT_PC_REG) &&
            (((ins[12:11] == 2'h0) && ins[6]) || (ins[12:10] == `OWIT_PFX_BITOP));
      end
   endfunction

   // true for branch, call and every return form
   function owit_flow;
      input [12:0] ins;
      begin
         owit_flow = (ins[12:11] == `OWIT_PFX_BRANCH) || (ins[12:10] == `OWIT_PFX_RETURN_WITH_LITERAL) ||
            (ins == `OWIT_OP_RET) || (ins == `OWIT_OP_RETURN_FROM_IRQ);
      end
   endfunction

   // true for conditional skips
   function owit_skip;
      input [12:0] ins;
      begin
         owit_skip = (ins[12:10] == `OWIT_PFX_BITSKIP) ||
            ((ins[12:11] == 2'h0) && ins[7] &&
             ((ins[11:8] == `OWIT_GRP_DEC_SKIP) || (ins[11:8] == `OWIT_GRP_INC_SKIP)));
      end
   endfunction

   owit_opt_store u_store (
      .i_clk(i_clk),
      .i_we(prog_wr),
      .i_waddr(i_addr),
      .i_wdata(wr_word),
      .i_ra_addr(i_addr),
      .o_ra_data(mem_a),
      .i_rb_addr(load_idx),
      .o_rb_data(mem_b)
   );

   owit_cycle_gen u_cycle (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(running),
      .i_four(o_four_period),
      .o_icycle(icycle),
      .o_tmr_tick(o_tmr_tick)
   );

   // option store reachable only from the programming path
   assign prog_wr = i_wr && i_prog_mode && (i_addr != `OWIT_ADDR_STAT);
   assign wr_word = (i_addr == `OWIT_ADDR_W1) ? (i_wdata[12:0] & `OWIT_W1_MASK) : i_wdata[12:0];

   // shared reset pin passes two flops before use
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end else begin
         pin_s1 <= i_reset_pin;
         pin_s2 <= pin_s1;
      end
   end

   assign pin_reset = o_reset_pin_en && !pin_s2;
   assign o_reset_pin_en = !opt_w0[`OWIT_W0_RESET_PIN];
   assign o_wdt_en = !opt_w0[`OWIT_W0_WDT_OFF];
   assign o_four_period = opt_w0[`OWIT_W0_CYC_LEN];
   assign o_osc_mode = opt_w0[`OWIT_W0_OSC_HI:`OWIT_W0_OSC_LO];
   assign o_irc_sel = (o_osc_mode == `OWIT_OSC_IRC);
   assign o_code_protect = !opt_w0[`OWIT_W0_PROT];
   assign o_osc_out_en = opt_w0[`OWIT_W0_OSC_OUT];
   assign o_rc_freq_sel = opt_w1[`OWIT_W1_RCF_HI:`OWIT_W1_RCF_LO];
   assign o_cust_id = opt_w2[`OWIT_W2_ID_HI:`OWIT_W2_ID_LO];
   assign cfg_ok = !opt_w0[`OWIT_W0_TYPE] && (&opt_w0[`OWIT_W0_TRIM_HI:`OWIT_W0_TRIM_LO]);

   assign running = (state == ST_RUN) && !pin_reset;
   assign o_core_rst_n = running || (state == ST_SLEEP);
   assign o_fetch = running && icycle && !extra_cycle;

   // set-up delay picked from the latched option
   always @* begin
      case (opt_w0[`OWIT_W0_SUT_HI:`OWIT_W0_SUT_LO])
         `OWIT_SUT_18: setup_lim = SETUP_18_CYC[23:0];
         `OWIT_SUT_4P5: setup_lim = SETUP_4P5_CYC[23:0];
         `OWIT_SUT_288: setup_lim = SETUP_288_CYC[23:0];
         default: setup_lim = SETUP_72_CYC[23:0];
      endcase
   end

   // load, set-up and run sequencing
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= ST_LOAD;
         load_idx <= 2'h0;
         setup_cnt <= 24'h000000;
         opt_w0 <= `OWIT_W0_ERASED;
         opt_w1 <= `OWIT_W1_ERASED;
         opt_w2 <= `OWIT_W2_ERASED;
      end else if (pin_reset && state != ST_LOAD) begin
         state <= ST_LOAD;
         load_idx <= 2'h0;
         setup_cnt <= 24'h000000;
      end else begin
         case (state)
            ST_LOAD: begin
               // store data trail the index by one clock
               load_idx <= load_idx + 2'h1;
               if (load_idx == 2'h1) opt_w0 <= mem_b;
               if (load_idx == 2'h2) opt_w1 <= mem_b;
               if (load_idx == 2'h3) begin
                  opt_w2 <= mem_b;
                  state <= ST_SETUP;
                  setup_cnt <= 24'h000000;
               end
            end
            ST_SETUP: begin
               if (setup_cnt >= setup_lim - 24'h000001) begin
                  state <= ST_RUN;
               end else begin
                  setup_cnt <= setup_cnt + 24'h000001;
               end
            end
            ST_RUN: begin
               if (i_instr_valid && i_instr == `OWIT_OP_SLEEP) begin
                  state <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               // oscillator restarts, so the set-up delay runs again
               if (i_wake) begin
                  state <= ST_SETUP;
                  setup_cnt <= 24'h000000;
               end
            end
            default: state <= ST_LOAD;
         endcase
      end
   end

   // instruction decode and cycle stretching
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         extra_cycle <= 1'b0;
         o_two_cycle <= 1'b0;
         o_sleep_req <= 1'b0;
         o_osc_stop <= 1'b0;
         o_wdt_clear <= 1'b0;
         o_to_flag <= 1'b1;
         o_pd_flag <= 1'b1;
         o_stack_pop <= 1'b0;
         o_irq_enable <= 1'b0;
         o_bit_op <= 1'b0;
         o_bit_mask <= 8'h00;
         o_reg_sel <= 6'h00;
      end else begin
         o_sleep_req <= 1'b0;
         o_wdt_clear <= 1'b0;
         o_stack_pop <= 1'b0;
         o_irq_enable <= 1'b0;
         o_bit_op <= 1'b0;
         if (running && icycle && extra_cycle) begin
            extra_cycle <= 1'b0;
         end
         if (state == ST_SLEEP && i_wake) begin
            o_osc_stop <= 1'b0;
         end
         if (running && i_instr_valid) begin
            // 13-bit word: operand register in [5:0], bit index in [9:7]
            o_reg_sel <= i_instr[5:0];
            if (owit_pc_write(i_instr) || owit_flow(i_instr) ||
                (owit_skip(i_instr) && i_skip_taken)) begin
               extra_cycle <= 1'b1;
               o_two_cycle <= 1'b1;
            end else begin
               o_two_cycle <= 1'b0;
            end
            if (i_instr[12:11] == 2'h1) begin
               // any register, including I/O, takes a bit operation
               o_bit_op <= 1'b1;
               o_bit_mask <= 8'h01 << i_instr[9:7];
            end
            if (i_instr == `OWIT_OP_SLEEP) begin
               o_sleep_req <= 1'b1;
               o_osc_stop <= 1'b1;
               o_wdt_clear <= 1'b1;
               o_to_flag <= 1'b1;
               o_pd_flag <= 1'b0;
            end
            if (i_instr == `OWIT_OP_WDT_CLR) begin
               o_wdt_clear <= 1'b1;
               o_to_flag <= 1'b1;
               o_pd_flag <= 1'b1;
            end
            if (i_instr == `OWIT_OP_RET || i_instr == `OWIT_OP_RETURN_FROM_IRQ ||
                i_instr[12:10] == `OWIT_PFX_RETURN_WITH_LITERAL) begin
               o_stack_pop <= 1'b1;
            end
            if (i_instr == `OWIT_OP_RETURN_FROM_IRQ) begin
               o_irq_enable <= 1'b1;
            end
         end
      end
   end

   // register port read side, data valid only in the cycle after the strobe
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_pend <= 1'b0;
         rd_stat <= 1'b0;
         status_q <= 16'h0000;
      end else begin
         rd_pend <= i_rd && i_prog_mode;
         rd_stat <= (i_addr == `OWIT_ADDR_STAT);
         status_q <= {8'h00, o_osc_stop, o_pd_flag, o_to_flag, o_core_rst_n, cfg_ok, state};
      end
   end

   assign o_rdata = !rd_pend ? 16'h0000 : (rd_stat ? status_q : {3'h0, mem_a});
endmodule

// File: owit_map.vh
/*
 Constants of the option loader and timing block: offsets,
 field positions, erased values, timing figures, encodings.
 Assumes inclusion by bare name.
*/
`ifndef OWIT_MAP_VH
`define OWIT_MAP_VH

// register port offsets
`define OWIT_ADDR_W0 2'h0
`define OWIT_ADDR_W1 2'h1
`define OWIT_ADDR_W2 2'h2
`define OWIT_ADDR_STAT 2'h3

// option word 0 field positions
`define OWIT_W0_RESET_PIN 12
`define OWIT_W0_WDT_OFF 11
`define OWIT_W0_CYC_LEN 10
`define OWIT_W0_OSC_HI 9
`define OWIT_W0_OSC_LO 8
`define OWIT_W0_PROT 7
`define OWIT_W0_SUT_HI 6
`define OWIT_W0_SUT_LO 5
`define OWIT_W0_TYPE 4
`define OWIT_W0_OSC_OUT 3
`define OWIT_W0_TRIM_HI 2
`define OWIT_W0_TRIM_LO 0
// option word 1 field positions
`define OWIT_W1_RCF_HI 1
`define OWIT_W1_RCF_LO 0
// option word 2 field positions
`define OWIT_W2_ID_HI 12
`define OWIT_W2_ID_LO 0

// erased values of the option store and writable masks
`define OWIT_W0_ERASED 13'h1FFF
`define OWIT_W1_ERASED 13'h0003
`define OWIT_W2_ERASED 13'h1FFF
`define OWIT_W1_MASK 13'h0003

// oscillator mode and set-up delay codes
`define OWIT_OSC_IRC 2'h3
`define OWIT_SUT_18 2'h3
`define OWIT_SUT_4P5 2'h2
`define OWIT_SUT_288 2'h1
`define OWIT_SUT_72 2'h0

// clock rate and set-up delays in microseconds
`define OWIT_CLK_KHZ 40000
`define OWIT_SUT_18_US 18000
`define OWIT_SUT_4P5_US 4500
`define OWIT_SUT_288_US 288000
`define OWIT_SUT_72_US 72000

// oscillator periods per instruction cycle, minus one
`define OWIT_CYC2_LAST 2'h1
`define OWIT_CYC4_LAST 2'h3

// instruction encodings
`define OWIT_OP_SLEEP 13'h0003
`define OWIT_OP_WDT_CLR 13'h0004
`define OWIT_OP_RET 13'h0012
`define OWIT_OP_RETURN_FROM_IRQ 13'h0013
`define OWIT_PC_REG 6'h02
`define OWIT_PFX_BITOP 3'h2
`define OWIT_PFX_BITSKIP 3'h3
`define OWIT_PFX_BRANCH 2'h2
`define OWIT_PFX_RETURN_WITH_LITERAL 3'h6
`define OWIT_GRP_DEC_SKIP 4'h5
`define OWIT_GRP_INC_SKIP 4'h7

`endif

// File: owit_opt_store.v
/*
 Nonvolatile option store model: three 13-bit option words, one write
 port and two read ports whose data come out of registers.
 Assumes writes arrive only from the programming path; contents are not
 touched by reset, since the store keeps its words across power cycles.
*/
`include "owit_map.vh"

module owit_opt_store (
   input wire i_clk,             // oscillator clock
   input wire i_we,              // write strobe
   input wire [1:0] i_waddr,     // write word index
   input wire [12:0] i_wdata,    // write data
   input wire [1:0] i_ra_addr,   // read port a word index
   output reg [12:0] o_ra_data,  // read port a data, one cycle later
   input wire [1:0] i_rb_addr,   // read port b word index
   output reg [12:0] o_rb_data   // read port b data, one cycle later
);
   reg [12:0] word0;
   reg [12:0] word1;
   reg [12:0] word2;

   function [12:0] owit_pick;
      input [1:0] idx;
      begin
         case (idx)
            `OWIT_ADDR_W0: owit_pick = word0;
            `OWIT_ADDR_W1: owit_pick = word1;
            `OWIT_ADDR_W2: owit_pick = word2;
            default: owit_pick = 13'h0000;
         endcase
      end
   endfunction

   initial begin
      word0 = `OWIT_W0_ERASED;
      word1 = `OWIT_W1_ERASED;
      word2 = `OWIT_W2_ERASED;
   end

   always @(posedge i_clk) begin
      if (i_we && i_waddr == `OWIT_ADDR_W0) word0 <= i_wdata;
      if (i_we && i_waddr == `OWIT_ADDR_W1) word1 <= i_wdata;
      if (i_we && i_waddr == `OWIT_ADDR_W2) word2 <= i_wdata;
      o_ra_data <= owit_pick(i_ra_addr);
      o_rb_data <= owit_pick(i_rb_addr);
   end
endmodule

// File: owit_cycle_gen.v
/*
 Instruction cycle generator: two or four clocks per cycle,
 timer/counter tick at the same rate.
 Assumes i_run drops while the core is held or asleep.
*/
`include "owit_map.vh"

module owit_cycle_gen (
   input wire i_clk,        // oscillator clock
   input wire i_rst_n,      // synchronous reset, active low
   input wire i_run,        // core running, oscillator active
   input wire i_four,       // four periods per instruction cycle
   output wire o_icycle,    // pulse at the last period of each cycle
   output wire o_tmr_tick   // timer/counter internal clock pulse
);
   reg [1:0] phase;
   wire [1:0] last = i_four ? `OWIT_CYC4_LAST : `OWIT_CYC2_LAST;

   always @(posedge i_clk) begin
      if (!i_rst_n || !i_run) begin
         phase <= 2'h0;
      end else if (phase >= last) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   assign o_icycle = i_run && (phase == last);
   assign o_tmr_tick = o_icycle;               // Fosc/2 or Fosc/4
endmodule

// File: owit_chk.sv
/*
 Port-level assertions and covers of owit_loader.
 Assumes binding to each instance, one clock.
*/
module owit_chk (
   input wire i_clk, i_rst_n, i_reset_pin, i_instr_valid,
   input wire [12:0] i_instr, o_cust_id,
   input wire o_core_rst_n, o_osc_stop, o_tmr_tick, o_four_period, o_reset_pin_en, o_irc_sel,
   input wire [1:0] o_osc_mode,
   input wire o_sleep_req, o_wdt_clear, o_to_flag, o_pd_flag, o_stack_pop, o_irq_enable,
   input wire o_bit_op, o_two_cycle,
   input wire [7:0] o_bit_mask,
   input wire [5:0] o_reg_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   // an instruction is only taken while the core runs and the oscillator is on
   wire take = i_instr_valid && o_core_rst_n && !o_osc_stop;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_pin; (o_reset_pin_en && !i_reset_pin) [*5] |-> !o_core_rst_n; endproperty
   a_pin: assert property (p_pin) else $error("pin reset ignored");
   property p_hold; $rose(i_rst_n) |-> !o_core_rst_n [*4]; endproperty
   a_hold: assert property (p_hold) else $error("early core release");
   property p_tick2; o_tmr_tick && !o_four_period |=> !o_tmr_tick; endproperty
   a_tick2: assert property (p_tick2) else $error("tick spacing, 2 periods");
   property p_tick4; o_tmr_tick && o_four_period |=> !o_tmr_tick [*3]; endproperty
   a_tick4: assert property (p_tick4) else $error("tick spacing, 4 periods");
   property p_irc; o_irc_sel == (o_osc_mode == 2'h3); endproperty
   a_irc: assert property (p_irc) else $error("irc select wrong");
   property p_slp;
      take && i_instr == 13'h0003 |=> o_sleep_req && o_wdt_clear && o_osc_stop && o_to_flag && !o_pd_flag;
   endproperty
   a_slp: assert property (p_slp) else $error("sleep effects");
   property p_wdc; take && i_instr == 13'h0004 |=> o_wdt_clear && !o_sleep_req && o_to_flag && o_pd_flag; endproperty
   a_wdc: assert property (p_wdc) else $error("wdt clear effects");
   property p_ret; take && i_instr[12:1] == 12'h009 |=> o_stack_pop && o_irq_enable == $past(i_instr[0]); endproperty
   a_ret: assert property (p_ret) else $error("return effects");
   property p_bit;
      take && i_instr[12:11] == 2'h1 |=> o_bit_op && o_bit_mask == 8'h01 << $past(i_instr[9:7])
         && o_reg_sel == $past(i_instr[5:0]);
   endproperty
   a_bit: assert property (p_bit) else $error("bit op decode");
   property p_two; take && (i_instr[12:11] == 2'h2 || i_instr == 13'h0042) |=> o_two_cycle; endproperty
   a_two: assert property (p_two) else $error("two-cycle missing");
   property p_opt;
      o_core_rst_n && $past(o_core_rst_n) |-> $stable({o_reset_pin_en, o_four_period, o_osc_mode, o_cust_id});
   endproperty
   a_opt: assert property (p_opt) else $error("options changed");
   c_sleep: cover property (o_sleep_req);
   c_two: cover property ($rose(o_two_cycle));
   c_run: cover property ($rose(o_core_rst_n));
endmodule

bind owit_loader owit_chk i_owit_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_pin(i_reset_pin), .i_instr_valid(i_instr_valid),
   .i_instr(i_instr), .o_cust_id(o_cust_id), .o_core_rst_n(o_core_rst_n), .o_osc_stop(o_osc_stop),
   .o_tmr_tick(o_tmr_tick), .o_four_period(o_four_period), .o_reset_pin_en(o_reset_pin_en),
   .o_irc_sel(o_irc_sel), .o_osc_mode(o_osc_mode), .o_sleep_req(o_sleep_req), .o_wdt_clear(o_wdt_clear),
   .o_to_flag(o_to_flag), .o_pd_flag(o_pd_flag), .o_stack_pop(o_stack_pop), .o_irq_enable(o_irq_enable),
   .o_bit_op(o_bit_op), .o_two_cycle(o_two_cycle), .o_bit_mask(o_bit_mask), .o_reg_sel(o_reg_sel));

// File: owit_prog.sv
/*
 Programmer model: option store access over the register port.
 Assumes one access at a time, called by the bench.
*/
module owit_prog #(
   parameter WAKE_USED = 1
) (
   input wire i_clk,            // oscillator clock
   input wire [15:0] i_rdata,   // read data
   output logic [1:0] o_addr,   // register address
   output logic [15:0] o_wdata, // write data
   output logic o_wr,           // write strobe
   output logic o_rd,           // read strobe
   output logic o_prog          // programmer attached
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_addr = 2'h0;
      o_wdata = 16'h0000;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_prog = 1'b0;
   end
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (a == 2'h0) begin
         v[4] = 1'b0;
         v[2:0] = 3'h7;
         if (WAKE_USED) v[11] = 1'b0;
      end
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= v;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      // released data lines must not keep the last value
      o_wdata <= ~v;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      @(negedge i_clk);
      d = i_rdata;
   endtask
   task automatic attach(input logic on);
      @(posedge i_clk);
      o_prog <= on;
   endtask
endmodule

// File: owit_loader_bench.sv
/*
 Self-checking bench of owit_loader, small set-up counts.
 Assumes owit_prog and the bound owit_chk.
*/
module owit_loader_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_reset_pin = 1'b1, i_wake = 1'b0;
   logic i_instr_valid = 1'b0, i_skip_taken = 1'b0;
   logic [12:0] i_instr = 13'h0000;
   wire [1:0] i_addr, o_osc_mode, o_rc_freq_sel;
   wire [15:0] i_wdata, o_rdata;
   wire i_wr, i_rd, i_prog_mode, o_core_rst_n, o_fetch, o_tmr_tick, o_reset_pin_en, o_wdt_en;
   wire o_four_period, o_irc_sel, o_code_protect, o_osc_out_en, o_two_cycle, o_sleep_req, o_osc_stop;
   wire o_wdt_clear, o_to_flag, o_pd_flag, o_stack_pop, o_irq_enable, o_bit_op;
   wire [12:0] o_cust_id;
   wire [7:0] o_bit_mask;
   wire [5:0] o_reg_sel;
   integer mismatches = 0, checked = 0, cyc = 0, n, f, t, k;
   logic [15:0] d;
   logic [4:0] p;
   // ops, skip bits, pulses {sleep,wdt,pop,irq,bit}, fetches
   localparam logic [12:0] OPS [10] = '{13'h1000, 13'h0042, 13'h0583, 13'h0583, 13'h0000,
      13'h0012, 13'h0013, 13'h0004, 13'h0985, 13'h1805};
   localparam logic [9:0] SKP = 10'h004;
   localparam logic [4:0] PUL [10] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h04, 5'h06, 5'h08, 5'h01, 5'h04};
   localparam int FC [10] = '{5, 5, 5, 6, 6, 5, 5, 6, 6, 5};
   localparam logic [15:0] WV [3] = '{16'h0147, 16'hFFFD, 16'h0ABC};
   localparam logic [15:0] EV [3] = '{16'h0147, 16'h0001, 16'h0ABC};

   owit_loader #(.SETUP_18_CYC(20), .SETUP_4P5_CYC(5)) i_owit_loader (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_prog_mode(i_prog_mode), .i_reset_pin(i_reset_pin), .i_wake(i_wake),
      .i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_skip_taken(i_skip_taken),
      .o_core_rst_n(o_core_rst_n), .o_fetch(o_fetch), .o_tmr_tick(o_tmr_tick), .o_reset_pin_en(o_reset_pin_en),
      .o_wdt_en(o_wdt_en), .o_four_period(o_four_period), .o_osc_mode(o_osc_mode), .o_irc_sel(o_irc_sel),
      .o_code_protect(o_code_protect), .o_osc_out_en(o_osc_out_en), .o_rc_freq_sel(o_rc_freq_sel),
      .o_cust_id(o_cust_id), .o_two_cycle(o_two_cycle), .o_sleep_req(o_sleep_req), .o_osc_stop(o_osc_stop),
      .o_wdt_clear(o_wdt_clear), .o_to_flag(o_to_flag), .o_pd_flag(o_pd_flag), .o_stack_pop(o_stack_pop),
      .o_irq_enable(o_irq_enable), .o_bit_op(o_bit_op), .o_bit_mask(o_bit_mask), .o_reg_sel(o_reg_sel));
   owit_prog i_owit_prog (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
      .o_wr(i_wr), .o_rd(i_rd), .o_prog(i_prog_mode));

   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked = checked + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset(output int c);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      c = 0;
      do begin
         @(negedge i_clk);
         c++;
      end while (o_core_rst_n !== 1'b1 && c < 300);
   endtask
   task automatic count(input int win, output int fc, output int tc);
      fc = 0;
      tc = 0;
      repeat (win) begin
         @(negedge i_clk);
         fc += (o_fetch === 1'b1);
         tc += (o_tmr_tick === 1'b1);
      end
   endtask
   task automatic wait_fetch();
      int c;
      c = 0;
      do begin
         @(negedge i_clk);
         c++;
      end while (o_fetch !== 1'b1 && c < 100);
   endtask
   // one instruction after a fetch: pulses and fetches
   task automatic exec(input logic [12:0] ins, input logic sk, output logic [4:0] pu, output int fc);
      int f0, tc;
      wait_fetch();
      @(posedge i_clk);
      i_instr_valid <= 1'b1;
      i_instr <= ins;
      i_skip_taken <= sk;
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      @(negedge i_clk);
      pu = {o_sleep_req, o_wdt_clear, o_stack_pop, o_irq_enable, o_bit_op};
      f0 = (o_fetch === 1'b1);
      count(o_four_period ? 23 : 11, fc, tc);
      fc += f0;
   endtask
   task automatic t_pin(input logic exp_run);
      @(posedge i_clk);
      i_reset_pin <= 1'b0;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      chk("pin_core_run", exp_run, o_core_rst_n);
      @(posedge i_clk);
      i_reset_pin <= 1'b1;
      wait_fetch();
      chk("pin_recover", 1'b1, o_core_rst_n);
      $display("test pin reset done");
   endtask
   task automatic t_erased();
      do_reset(n);
      chk("setup_long", 1'b1, n >= 22 && n <= 29);
      chk("opts_erased", 16'h00F7, {o_reset_pin_en, o_wdt_en, o_four_period, o_osc_mode, o_irc_sel,
         o_code_protect, o_osc_out_en, o_rc_freq_sel});
      count(24, f, t);
      chk("fetch4", 16'd6, f[15:0]);
      chk("tick4", 16'd6, t[15:0]);
      $display("test erased options done");
   endtask
   task automatic t_program();
      i_owit_prog.attach(1'b1);
      for (k = 0; k < 3; k++) i_owit_prog.wr(k[1:0], WV[k]);
      i_owit_prog.wr(2'h3, 16'h1FFF);
      for (k = 0; k < 3; k++) begin
         i_owit_prog.rd(k[1:0], d);
         chk("word_back", EV[k], d);
      end
      i_owit_prog.rd(2'h3, d);
      chk("status_hi", 16'h0000, {8'h00, d[15:8]});
      chk("id_live", 16'h1FFF, {3'h0, o_cust_id});
      i_owit_prog.attach(1'b0);
      i_owit_prog.rd(2'h0, d);
      chk("read_closed", 16'h0000, d);
      do_reset(n);
      chk("setup_short", 1'b1, n >= 7 && n <= 14);
      chk("opts_prog", 16'h0329, {o_reset_pin_en, o_wdt_en, o_four_period, o_osc_mode, o_irc_sel,
         o_code_protect, o_osc_out_en, o_rc_freq_sel});
      chk("id_new", 16'h0ABC, {3'h0, o_cust_id});
      count(12, f, t);
      chk("fetch2", 16'd6, f[15:0]);
      chk("tick2", 16'd6, t[15:0]);
      $display("test programmed options done");
   endtask
   task automatic t_instr();
      for (k = 0; k < 10; k++) begin
         exec(OPS[k], SKP[k], p, f);
         chk("pulses", {11'h000, PUL[k]}, {11'h000, p});
         chk("fetches", FC[k][15:0], f[15:0]);
         if (k == 7) chk("flags_wdc", 16'h0003, {14'h0000, o_to_flag, o_pd_flag});
         if (k == 8) chk("bit_sel", 16'h0805, {o_bit_mask, 2'h0, o_reg_sel});
      end
      exec(13'h0003, 1'b0, p, f);
      chk("sleep", 16'h0018, {11'h000, p});
      chk("sleep_state", 16'h0006, {13'h0000, o_osc_stop, o_to_flag, o_pd_flag});
      chk("sleep_fetch", 16'd0, f[15:0]);
      @(posedge i_clk);
      i_wake <= 1'b1;
      @(posedge i_clk);
      i_wake <= 1'b0;
      wait_fetch();
      chk("woken", 16'h0001, {14'h0000, o_osc_stop, o_fetch});
      $display("test instruction timing done");
   endtask

   initial begin
      t_erased();
      t_pin(1'b1);
      t_program();
      t_instr();
      t_pin(1'b0);
      end_of_test();
   end
endmodule
